// ===== core/spl_consts.svh
// Constants for the self-programming lock and fuse access block
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// ====================================================================
// Control register fields
`define SPL_PE_BIT        0
`define SPL_PAGE_ERASE_BIT_BIT     1
`define SPL_PAGE_WRITE_BIT_BIT     2
`define SPL_LOCK_BIT_SET_BIT    3
`define SPL_SECTION_READ_REENABLE_BIT    4
`define SPL_SBUSY_BIT     6
`define SPL_CTRL_RESET    8'h00
`define SPL_CMD_LOCK_SET  8'h09
`define SPL_CMD_REENABLE  8'h11

// ====================================================================
// Timing windows after a control write, in cycles
`define SPL_SPM_WINDOW    3'h4
`define SPL_LPM_WINDOW    3'h3

// ====================================================================
// Readback pointer values
`define SPL_PTR_FUSE_LOW  16'h0000
`define SPL_PTR_LOCK      16'h0001
`define SPL_PTR_FUSE_EXT  16'h0002
`define SPL_PTR_FUSE_HIGH 16'h0003
`define SPL_LOCK_RESET    6'h3F

// ====================================================================
// Flash write time, shortest legal, at the 50 MHz clock
`define SPL_WRITE_MIN_NS  3700000
`define SPL_WRITE_MAX_NS  4500000
`define SPL_CLK_NS        20
`define SPL_WRITE_CYCLES  ((`SPL_WRITE_MIN_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)

// ====================================================================
// Controller register map on Wishbone
`define SPL_REG_CMD       8'h00
`define SPL_REG_PTR       8'h04
`define SPL_REG_DATA      8'h08
`define SPL_REG_STATUS    8'h0C
`define SPL_CMD_LPM_BIT   8
`define SPL_CMD_RET_BIT   9

`endif

// ===== core/spl_device.sv
// Flash self-programming control: lock set, fuse and lock readback, write timing
`timescale 1ns/1ps
`include "spl_consts.svh"

module spl_device #(
    parameter int unsigned WRITE_CYCLES = `SPL_WRITE_CYCLES,
    parameter int unsigned TIMER_W      = 18
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    spl_link_if.dev          link,
    input  wire logic        eeprom_write_busy_i,
    input  wire logic [7:0]  fuse_low_i,
    input  wire logic [7:0]  fuse_high_i,
    input  wire logic [7:0]  fuse_ext_i,
    input  wire logic [5:0]  lock_init_i,
    input  wire logic [7:0]  flash_rdata_i,
    output logic      [15:0] flash_addr_o,
    output logic      [5:0]  lock_bits_o,
    output logic             flash_write_busy_o
);

    // ================================================================
    // State
    typedef struct packed {
        spl_pkg::spl_ctrl_t   ctrl;
        logic                 armed;
        logic [2:0]           win;
        logic                 writing;
        logic [TIMER_W-1:0]   timer;
        logic                 sbusy;
        logic [5:0]           lock;
        logic [7:0]           lpm_data;
        logic                 lpm_valid;
    } spl_dev_state_t;

    spl_dev_state_t s;
    spl_dev_state_t next_s;

    // ================================================================
    // Control value decode
    function automatic spl_pkg::spl_ctrl_t spl_decode(input logic [7:0] v);
        spl_pkg::spl_ctrl_t c;
        c.pe     = v[`SPL_PE_BIT];
        c.page_erase_bit  = v[`SPL_PAGE_ERASE_BIT_BIT];
        c.page_write_bit  = v[`SPL_PAGE_WRITE_BIT_BIT];
        c.lock_bit_set = v[`SPL_LOCK_BIT_SET_BIT];
        c.section_read_reenable = v[`SPL_SECTION_READ_REENABLE_BIT];
        return c;
    endfunction : spl_decode

    // ================================================================
    // Next state
    always_comb
    begin
        next_s           = s;
        next_s.lpm_valid = 1'b0;

        // Store and load windows run from the control write
        // The store window outlives the load window; a late load reads flash
        if (s.armed)
        begin
            if (s.win == `SPL_SPM_WINDOW - 3'h1)
            begin
                next_s.armed = 1'b0;
                next_s.ctrl  = spl_decode(`SPL_CTRL_RESET);
            end
            else
            begin
                next_s.win = s.win + 3'h1;
            end
        end

        // Write timer; enable stays up until the very end
        if (s.writing)
        begin
            if (s.timer == '0)
            begin
                next_s.writing = 1'b0;
                next_s.ctrl    = spl_decode(`SPL_CTRL_RESET);
            end
            else
            begin
                next_s.timer = s.timer - TIMER_W'(1);
            end
        end

        // A control write is dropped while EEPROM or flash is busy
        if (link.ctrl_we && !eeprom_write_busy_i && !s.writing)
        begin
            // Writing the enable bit opens a fresh window, even over an armed one
            next_s.ctrl  = spl_decode(link.ctrl_wdata);
            next_s.armed = link.ctrl_wdata[`SPL_PE_BIT];
            next_s.win   = 3'h0;
        end
        else if (link.spm && s.armed && !eeprom_write_busy_i)
        begin
            next_s.armed = 1'b0;
            if (s.ctrl.lock_bit_set || s.ctrl.page_erase_bit || s.ctrl.page_write_bit)
            begin
                next_s.writing = 1'b1;
                next_s.timer   = TIMER_W'(WRITE_CYCLES - 1);
                // Command bits drop now; only the enable bit marks the write
                next_s.ctrl    = spl_decode(`SPL_CTRL_RESET);
                next_s.ctrl.pe = 1'b1;
                // Lock set uses only the data byte, never the pointer
                if (s.ctrl.lock_bit_set)
                    next_s.lock = s.lock & link.data_lo[5:0];
                else
                    next_s.sbusy = 1'b1;
            end
            else
            begin
                // Re-enable or page load both free the busy section
                next_s.sbusy = 1'b0;
                next_s.ctrl  = spl_decode(`SPL_CTRL_RESET);
            end
        end

        // Loads always answer one cycle later
        // Readback needs the window still inside its first three cycles
        if (link.lpm)
        begin
            next_s.lpm_valid = 1'b1;
            next_s.lpm_data  = flash_rdata_i;
            if (s.armed && s.ctrl.lock_bit_set && s.win < `SPL_LPM_WINDOW
                && !eeprom_write_busy_i)
            begin
                next_s.armed = 1'b0;
                next_s.ctrl  = spl_decode(`SPL_CTRL_RESET);
                // Fuses arrive in programmed-is-zero polarity already
                unique case (link.ptr)
                    `SPL_PTR_FUSE_LOW:  next_s.lpm_data = fuse_low_i;
                    `SPL_PTR_LOCK:      next_s.lpm_data = {2'b11, s.lock};
                    `SPL_PTR_FUSE_EXT:  next_s.lpm_data = fuse_ext_i;
                    `SPL_PTR_FUSE_HIGH: next_s.lpm_data = fuse_high_i;
                    default:            next_s.lpm_data = flash_rdata_i;
                endcase
            end
        end

        // Reset clears control, but a write in flight runs to its end
        if (rst_i)
        begin
            next_s.armed     = 1'b0;
            next_s.win       = 3'h0;
            next_s.sbusy     = 1'b0;
            next_s.lpm_data  = 8'h00;
            next_s.lpm_valid = 1'b0;
            if (s.writing)
            begin
                next_s.ctrl    = spl_decode(`SPL_CTRL_RESET);
                next_s.ctrl.pe = 1'b1;
            end
            else
            begin
                // Power-up lands here too, while the busy flag is still unknown
                next_s.ctrl    = spl_decode(`SPL_CTRL_RESET);
                next_s.writing = 1'b0;
                next_s.timer   = '0;
                next_s.lock    = lock_init_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= next_s;
    end

    // ================================================================
    // Outputs; the processor is never stalled here, reads keep flowing
    // Section busy sits at bit 6; bits 7 and 5 always read as zero
    assign link.ctrl_rdata = {1'b0, s.sbusy, 1'b0, s.ctrl.section_read_reenable, s.ctrl.lock_bit_set,
                              s.ctrl.page_write_bit, s.ctrl.page_erase_bit, s.ctrl.pe};
    assign link.lpm_data          = s.lpm_data;
    assign link.lpm_valid         = s.lpm_valid;
    assign link.eeprom_write_busy = eeprom_write_busy_i;
    assign flash_addr_o           = link.ptr;
    assign lock_bits_o            = s.lock;
    assign flash_write_busy_o     = s.writing;

endmodule : spl_device

// ===== core/spl_host.sv
// Boot loader sequencer: runs timed control-write and store/load sequences
`timescale 1ns/1ps
`include "spl_consts.svh"

module spl_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    spl_link_if.cpu          link
);

    typedef struct packed {
        spl_pkg::spl_host_state_t st;
        logic [9:0]               cmd;
        logic [15:0]              ptr;
        logic [7:0]               data;
        logic [7:0]               result;
        logic                     ack;
        logic [31:0]              rdat;
    } spl_host_t;

    spl_host_t s;
    spl_host_t next_s;

    function automatic logic [31:0] spl_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction : spl_merge

    logic req;
    logic busy;
    logic sbusy;
    logic pe;
    logic [31:0] status;
    assign req    = wb_cyc_i && wb_stb_i;
    assign busy   = s.st != spl_pkg::SPL_IDLE;
    assign sbusy  = link.ctrl_rdata[`SPL_SBUSY_BIT];
    assign pe     = link.ctrl_rdata[`SPL_PE_BIT];
    assign status = {16'h0000, s.result, 4'h0, link.eeprom_write_busy, pe, sbusy, busy};

    // ================================================================
    // Bus slave and sequencer
    always_comb
    begin
        next_s     = s;
        next_s.ack = req && !s.ack;
        if (req && !s.ack)
        begin
            unique case (wb_adr_i)
                `SPL_REG_CMD:    next_s.rdat = {22'h0, s.cmd};
                `SPL_REG_PTR:    next_s.rdat = {16'h0000, s.ptr};
                `SPL_REG_DATA:   next_s.rdat = {24'h000000, s.data};
                `SPL_REG_STATUS: next_s.rdat = status;
                default:         next_s.rdat = 32'h00000000;
            endcase
        end
        // Writes land on the ack edge; the sequence owns the regs while busy
        if (req && s.ack && wb_we_i && !busy)
        begin
            unique case (wb_adr_i)
                `SPL_REG_CMD:
                begin
                    next_s.cmd = 10'(spl_merge({22'h0, s.cmd}, wb_dat_i, wb_sel_i));
                    next_s.st  = spl_pkg::SPL_WAIT_PE;
                    if (next_s.cmd[`SPL_CMD_RET_BIT])
                        next_s.cmd[7:0] = `SPL_CMD_REENABLE;
                end
                `SPL_REG_PTR:
                    next_s.ptr = 16'(spl_merge({16'h0000, s.ptr}, wb_dat_i, wb_sel_i));
                `SPL_REG_DATA:
                    next_s.data = 8'(spl_merge({24'h000000, s.data}, wb_dat_i, wb_sel_i));
                default:
                    next_s.st = s.st;
            endcase
        end

        unique case (s.st)
            spl_pkg::SPL_IDLE:
                next_s.st = next_s.st;
            spl_pkg::SPL_WAIT_PE:
                if (!pe)
                begin
                    // Return mode ends only once the section is readable
                    if (s.cmd[`SPL_CMD_RET_BIT] && !sbusy)
                        next_s.st = spl_pkg::SPL_IDLE;
                    else
                        next_s.st = spl_pkg::SPL_WAIT_EE;
                end
            spl_pkg::SPL_WAIT_EE:
                if (!link.eeprom_write_busy)
                    next_s.st = spl_pkg::SPL_WRITE;
            spl_pkg::SPL_WRITE:
                next_s.st = spl_pkg::SPL_ISSUE;
            spl_pkg::SPL_ISSUE:
                if (s.cmd[`SPL_CMD_LPM_BIT])
                    next_s.st = spl_pkg::SPL_WAIT_RD;
                else if (s.cmd[`SPL_CMD_RET_BIT])
                    next_s.st = spl_pkg::SPL_WAIT_PE;
                else
                    next_s.st = spl_pkg::SPL_IDLE;
            spl_pkg::SPL_WAIT_RD:
                if (link.lpm_valid)
                begin
                    next_s.result = link.lpm_data;
                    next_s.st     = spl_pkg::SPL_IDLE;
                end
            default:
                next_s.st = spl_pkg::SPL_IDLE;
        endcase

        if (rst_i)
        begin
            next_s.st     = spl_pkg::SPL_IDLE;
            next_s.cmd    = 10'h000;
            next_s.ptr    = `SPL_PTR_LOCK;
            next_s.data   = 8'hFF;
            next_s.result = 8'h00;
            next_s.ack    = 1'b0;
            next_s.rdat   = 32'h00000000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= next_s;
    end

    // ================================================================
    // Control write and instruction go out back to back, nothing between
    assign link.ctrl_we    = s.st == spl_pkg::SPL_WRITE;
    assign link.ctrl_wdata = s.cmd[7:0];
    assign link.spm        = s.st == spl_pkg::SPL_ISSUE && !s.cmd[`SPL_CMD_LPM_BIT];
    assign link.lpm        = s.st == spl_pkg::SPL_ISSUE && s.cmd[`SPL_CMD_LPM_BIT];
    assign link.ptr        = s.ptr;
    assign link.data_lo    = s.data;
    assign wb_ack_o        = s.ack;
    assign wb_dat_o        = s.rdat;

endmodule : spl_host

// ===== core/spl_link_if.sv
// Link between the processor side and the flash self-programming logic
`timescale 1ns/1ps

interface spl_link_if;
    logic        ctrl_we;
    logic [7:0]  ctrl_wdata;
    logic [7:0]  ctrl_rdata;
    logic        spm;
    logic        lpm;
    logic [15:0] ptr;
    logic [7:0]  data_lo;
    logic [7:0]  lpm_data;
    logic        lpm_valid;
    logic        eeprom_write_busy;

    modport dev (input ctrl_we, ctrl_wdata, spm, lpm, ptr, data_lo,
                 output ctrl_rdata, lpm_data, lpm_valid, eeprom_write_busy);
    modport cpu (output ctrl_we, ctrl_wdata, spm, lpm, ptr, data_lo,
                 input ctrl_rdata, lpm_data, lpm_valid, eeprom_write_busy);
endinterface : spl_link_if

// ===== core/spl_pkg.sv
// Types shared by both ends of the self-programming link
package spl_pkg;

    typedef enum logic [5:0] {
        SPL_IDLE    = 6'h01,
        SPL_WAIT_PE = 6'h02,
        SPL_WAIT_EE = 6'h04,
        SPL_WRITE   = 6'h08,
        SPL_ISSUE   = 6'h10,
        SPL_WAIT_RD = 6'h20
    } spl_host_state_t;

    typedef struct packed {
        logic pe;
        logic page_erase_bit;
        logic page_write_bit;
        logic lock_bit_set;
        logic section_read_reenable;
    } spl_ctrl_t;

endpackage : spl_pkg

// ===== testbench/selfprog_lock_fuse_access_bench.sv
// Self-checking bench: host and device joined, driven over Wishbone
`timescale 1ns/1ps

module selfprog_lock_fuse_access_bench;
    localparam int unsigned WC = 20;
    localparam logic [7:0]  FL = 8'h62;
    localparam logic [7:0]  FH = 8'hD9;
    localparam logic [7:0]  FE = 8'hFD;
    localparam logic [5:0]  LK = 6'h3B;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        ee_busy;
    logic [7:0]  flash_rd;
    logic [15:0] flash_addr;
    logic [5:0]  lock_bits;
    logic        wr_busy;
    logic [31:0] st;
    int          n_mismatch;
    int          checked;

    spl_link_if lk ();

    // ====================================================================
    // Design and checker
    spl_host i_spl_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .link(lk));
    spl_device #(.WRITE_CYCLES(WC)) i_spl_device (.clk_i(clk_i), .rst_i(rst_i), .link(lk),
        .eeprom_write_busy_i(ee_busy), .fuse_low_i(FL), .fuse_high_i(FH), .fuse_ext_i(FE),
        .lock_init_i(LK), .flash_rdata_i(flash_rd), .flash_addr_o(flash_addr),
        .lock_bits_o(lock_bits), .flash_write_busy_o(wr_busy));
    spl_link_asserts i_spl_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
        .ctrl_we(lk.ctrl_we), .ctrl_wdata(lk.ctrl_wdata), .ctrl_rdata(lk.ctrl_rdata),
        .spm(lk.spm), .lpm(lk.lpm), .lpm_valid(lk.lpm_valid),
        .eeprom_write_busy(lk.eeprom_write_busy));

    // Flash content depends on address so a stale address shows up
    assign flash_rd = ~flash_addr[7:0];

    always #10 clk_i = ~clk_i;

    // ====================================================================
    // Helpers
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        chk("bus ack", 32'h1, 32'(ack));
        if (ack !== 1'b1)
            wrap_up;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Polls until the host is idle and program enable reads clear
    task wait_idle(output logic [31:0] s);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, 8'h0C, 32'h0, s);
            n++;
        end
        while ((s[0] !== 1'b0 || s[2] !== 1'b0) && n < 100);
        if (s[0] !== 1'b0 || s[2] !== 1'b0)
        begin
            chk("idle", 32'h0, s);
            wrap_up;
        end
    endtask : wait_idle

    task op(input logic [31:0] cmd, input logic [15:0] p, input logic [7:0] d,
            output logic [31:0] s);
        wb(1'b1, 8'h04, 32'(p), s);
        wb(1'b1, 8'h08, 32'(d), s);
        wb(1'b1, 8'h00, cmd, s);
        wait_idle(s);
    endtask : op

    task wait_busy(input logic lvl, output int n);
        n = 0;
        while (wr_busy !== lvl && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (wr_busy !== lvl)
        begin
            chk("write busy", 32'(lvl), 32'(wr_busy));
            wrap_up;
        end
    endtask : wait_busy

    // ====================================================================
    // Scenarios
    task t_readback;
        logic [7:0] exp [4];
        exp = '{FL, {2'b11, LK}, FE, FH};
        wb(1'b0, 8'h10, 32'h0, st);
        chk("unmapped", 32'h0, st);
        for (int i = 0; i < 4; i++)
        begin
            op(32'h109, 16'(i), 8'hFF, st);
            chk("readback", 32'(exp[i]), 32'(st[15:8]));
        end
        op(32'h100, 16'h0042, 8'hFF, st);
        chk("plain load", 32'hBD, 32'(st[15:8]));
    endtask : t_readback

    task t_lock_set;
        int n;
        wb(1'b1, 8'h04, 32'h1234, st);
        wb(1'b1, 8'h08, 32'hEA, st);
        wb(1'b1, 8'h00, 32'h009, st);
        wait_busy(1'b1, n);
        chk("lock bits", 32'h2A, 32'(lock_bits));
        wait_busy(1'b0, n);
        chk("write time", 32'h1, 32'(n >= WC - 2 && n <= WC + 1));
        wait_idle(st);
        op(32'h109, 16'h0001, 8'hFF, st);
        chk("lock readback", 32'hEA, 32'(st[15:8]));
    endtask : t_lock_set

    task t_eeprom;
        @(posedge clk_i);
        ee_busy <= 1'b1;
        wb(1'b1, 8'h00, 32'h109, st);
        repeat (10) @(posedge clk_i);
        wb(1'b0, 8'h0C, 32'h0, st);
        chk("held by eeprom", 32'h9, st & 32'hF);
        @(posedge clk_i);
        ee_busy <= 1'b0;
        // Busy returns just as the control write goes out: device must drop it
        @(posedge clk_i);
        ee_busy <= 1'b1;
        wait_idle(st);
        chk("lock during eeprom", 32'hFE, 32'(st[15:8]));
        @(posedge clk_i);
        ee_busy <= 1'b0;
        op(32'h109, 16'h0001, 8'hFF, st);
        chk("lock after eeprom", 32'hEA, 32'(st[15:8]));
    endtask : t_eeprom

    task t_section;
        op(32'h003, 16'h0100, 8'hFF, st);
        chk("section busy", 32'h1, 32'(st[1]));
        op(32'h200, 16'h0100, 8'hFF, st);
        chk("section free", 32'h0, 32'(st[1]));
    endtask : t_section

    task t_reset_write;
        int n;
        wb(1'b1, 8'h08, 32'hC5, st);
        wb(1'b1, 8'h00, 32'h009, st);
        wait_busy(1'b1, n);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("busy over reset", 32'h1, 32'(wr_busy));
        chk("lock over reset", 32'h0, 32'(lock_bits));
        wait_busy(1'b0, n);
        chk("write ends", 32'h0, 32'(wr_busy));
    endtask : t_reset_write

    // ====================================================================
    // Main sequence
    initial
    begin
        clk_i      = 1'b0;
        rst_i      = 1'b1;
        cyc        = 1'b0;
        stb        = 1'b0;
        we         = 1'b0;
        adr        = 8'h00;
        wdat       = 32'h0;
        ee_busy    = 1'b0;
        n_mismatch = 0;
        checked    = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_readback;
        t_lock_set;
        t_eeprom;
        t_section;
        t_reset_write;
        wrap_up;
    end
endmodule : selfprog_lock_fuse_access_bench

// ===== testbench/spl_link_asserts.sv
// Concurrent checks on the link between the host sequencer and the device
`timescale 1ns/1ps

module spl_link_asserts (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ctrl_we,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic       spm,
    input wire logic       lpm,
    input wire logic       lpm_valid,
    input wire logic       eeprom_write_busy
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ====================================================================
    // Properties
    sequence s_lock_cmd;
        ctrl_we && ctrl_wdata == 8'h09 && !ctrl_rdata[0] && !eeprom_write_busy;
    endsequence
    property p_answer;
        lpm |=> lpm_valid;
    endproperty
    property p_no_spurious;
        lpm_valid |-> $past(lpm);
    endproperty
    property p_arm;
        s_lock_cmd |=> ctrl_rdata[3:0] == 4'h9;
    endproperty
    property p_ee_hold;
        eeprom_write_busy && !ctrl_rdata[0] |=> !ctrl_rdata[0];
    endproperty
    property p_read_clear;
        lpm && ctrl_rdata[3:0] == 4'h9 && !eeprom_write_busy |=> ctrl_rdata[3:0] == 4'h0;
    endproperty
    property p_lock_hold;
        spm && ctrl_rdata[3:0] == 4'h9 && !eeprom_write_busy |=> ctrl_rdata[3:0] == 4'h1 [*8];
    endproperty
    property p_issue;
        ctrl_we |=> (spm || lpm) && !ctrl_we;
    endproperty
    property p_section;
        ctrl_we && ctrl_wdata == 8'h11 && !ctrl_rdata[0] && !eeprom_write_busy
            ##1 spm && !eeprom_write_busy
            |=> !ctrl_rdata[6];
    endproperty

    // ====================================================================
    // Assertions
    a_answer: assert property (p_answer)
        else $error("load not answered in the next cycle");
    a_no_spurious: assert property (p_no_spurious)
        else $error("load answer without a load");
    a_arm: assert property (p_arm)
        else $error("lock command not armed");
    a_ee_hold: assert property (p_ee_hold)
        else $error("control armed during eeprom write");
    a_read_clear: assert property (p_read_clear)
        else $error("control bits not cleared after readback");
    a_lock_hold: assert property (p_lock_hold)
        else $error("program enable dropped during lock write");
    a_issue: assert property (p_issue)
        else $error("control write not followed by store or load");
    a_section: assert property (p_section)
        else $error("section busy not cleared by re-enable");

    c_lock: cover property (s_lock_cmd ##1 spm);
    c_read: cover property (lpm ##1 lpm_valid);
    c_ee: cover property (eeprom_write_busy && ctrl_we);
endmodule : spl_link_asserts
